// ===== acp_pkg.sv
// package of constants and carrier types for the converter control-pin logic
`default_nettype none
package acp_pkg;
    // ****************************************************************
    // widths and codes
    // ****************************************************************
    localparam int unsigned DATA_W = 16;                 // result width
    localparam logic [15:0] DATA_ZERO = 16'h0000;        // cleared outputs
    localparam logic [1:0]  RANGE_0_5 = 2'h0;            // 0 to 5 V
    localparam logic [1:0]  RANGE_0_10 = 2'h1;           // 0 to 10 V
    localparam logic [1:0]  RANGE_PM5 = 2'h2;            // +/-5 V
    localparam logic [1:0]  RANGE_PM10 = 2'h3;           // +/-10 V
    localparam logic [7:0]  CFG_CLEAR = 8'h00;           // cleared configuration
    localparam logic [5:0]  CONV_CYCLES = 6'h14;         // conversion length, cycles
    localparam logic [5:0]  CNT_ZERO = 6'h00;            // idle counter
    localparam logic [5:0]  CNT_ONE = 6'h01;             // counter step

    // ****************************************************************
    // carrier types
    // ****************************************************************
    // static range pins as driven by the host
    typedef struct packed {
        logic signed_range;                              // bipolar select
        logic span_double_select;                        // doubled span
    } acp_range_pins_t;

    // host read-side strobes, active low
    typedef struct packed {
        logic cs_n;                                      // output chip select
        logic rd_n;                                      // read strobe
    } acp_read_pins_t;
endpackage
`default_nettype wire

// ===== acp_sync2.sv
// two-flop synchroniser bank for asynchronous pin inputs
`default_nettype none
module acp_sync2 #(
    parameter int unsigned W = 1                         // bits synchronised
) (
    // clock and reset
    input  wire logic         core_clk_i,
    input  wire logic         rst_i,
    // data
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_r;                                // first stage, read only by second
    // ****************************************************************
    // two flops in series
    // ****************************************************************
    // reset to zero so no pin appears active straight after reset
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            meta_r <= '0;
            sync_o <= '0;
        end else begin
            meta_r <= async_i;
            sync_o <= meta_r;
        end
    end
endmodule
`default_nettype wire

// ===== acp_ctrl.sv
// control-pin logic: range select, bus enable, reset, power-down
// Summary of operation
// - two pins select one of four ranges while config bit 7 is clear
// - output bus enabled only when cs and rd low
// - slave serial clock gated by chip select
// - configuration port ignores output chip select
// - reset high aborts conversion, no result
// - reset fall zeroes data when coding pin high
// - reset fall clears configuration register
// - power-down lets conversion finish, blocks new ones
// - interface stays live during power-down
`default_nettype none
module acp_ctrl
    import acp_pkg::*;
(
    // clock and device reset
    input  wire logic                 core_clk_i,
    input  wire logic                 rst_i,
    // device pins from host (asynchronous)
    input  wire logic                 dev_reset_i,
    input  wire logic                 power_down_i,
    input  wire logic                 output_coding_select_i,
    input  wire acp_pkg::acp_range_pins_t range_pins_i,
    input  wire acp_pkg::acp_read_pins_t  read_pins_i,
    input  wire logic                 slave_mode_i,
    input  wire logic                 ext_sclk_i,
    input  wire logic                 cfg_sel_n_i,
    input  wire logic                 cfg_clk_i,
    input  wire logic                 cfg_din_i,
    input  wire logic                 conv_start_i,
    // result from the converter core (same clock)
    input  wire logic [DATA_W-1:0]    core_result_i,
    // outputs
    output logic      [DATA_W-1:0]    data_o,
    output logic                      data_oe_o,
    output logic      [1:0]           range_o,
    output logic                      busy_o,
    output logic                      result_valid_o,
    output logic                      sclk_edge_o,
    output logic                      powered_down_o,
    output logic      [7:0]           cfg_o
);
    // ****************************************************************
    // pin synchronisation
    // ****************************************************************
    localparam int unsigned NSYNC = 13;                  // synchronised pin count
    logic [NSYNC-1:0] pins_raw;                          // raw pin vector
    logic [NSYNC-1:0] pins_s;                            // synchronised pins
    // active-low pins travel inverted, so the all-zero reset state of the
    // synchroniser reads as idle instead of as a selected bus
    assign pins_raw = {dev_reset_i, power_down_i, output_coding_select_i,
                       range_pins_i, ~{read_pins_i.cs_n, read_pins_i.rd_n},
                       slave_mode_i, ext_sclk_i,
                       ~cfg_sel_n_i, cfg_clk_i, cfg_din_i, conv_start_i};

    acp_sync2 #(.W(NSYNC)) u_sync (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .async_i    (pins_raw),
        .sync_o     (pins_s)
    );

    logic reset_s, pd_s, coding_s, sgn_s, dbl_s, cs_s, rd_s;
    logic slave_s, sclk_s, csel_s, cclk_s, cdin_s, start_s;
    logic cs_n_s, rd_n_s, csel_n_s;                      // active-low views
    assign {reset_s, pd_s, coding_s, sgn_s, dbl_s, cs_s, rd_s,
            slave_s, sclk_s, csel_s, cclk_s, cdin_s, start_s} = pins_s;
    assign cs_n_s   = ~cs_s;
    assign rd_n_s   = ~rd_s;
    assign csel_n_s = ~csel_s;

    // ****************************************************************
    // edge history
    // ****************************************************************
    logic reset_d_r;                                     // reset, last cycle
    logic sclk_d_r;                                      // serial clock, last cycle
    logic cclk_d_r;                                      // config clock, last cycle
    logic start_d_r;                                     // start, last cycle
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            reset_d_r <= 1'b0;
            sclk_d_r  <= 1'b0;
            cclk_d_r  <= 1'b0;
            start_d_r <= 1'b0;
        end else begin
            reset_d_r <= reset_s;
            sclk_d_r  <= sclk_s;
            cclk_d_r  <= cclk_s;
            start_d_r <= start_s;
        end
    end
    logic reset_fall;                                    // reset just released
    logic start_rise;                                    // conversion request
    assign reset_fall = reset_d_r & ~reset_s;
    assign start_rise = start_s & ~start_d_r;

    // ****************************************************************
    // range decode
    // ****************************************************************
    // pins steer the range; the config register can override when bit 7 set
    logic [1:0] range_nxt;
    always_comb begin
        range_nxt = {sgn_s, dbl_s};
        if (cfg_o[7]) begin
            range_nxt = cfg_o[1:0];
        end
    end
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            range_o <= RANGE_0_5;
        end else begin
            range_o <= range_nxt;
        end
    end

    // ****************************************************************
    // output bus enable
    // ****************************************************************
    // live regardless of power-down so the host can still read
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            data_oe_o <= 1'b0;
        end else begin
            data_oe_o <= ~cs_n_s & ~rd_n_s;
        end
    end

    // ****************************************************************
    // slave serial clock gating
    // ****************************************************************
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            sclk_edge_o <= 1'b0;
        end else begin
            // edges outside chip select are dropped
            sclk_edge_o <= slave_s & ~cs_n_s & sclk_s & ~sclk_d_r;
        end
    end

    // ****************************************************************
    // configuration shift register
    // ****************************************************************
    // governed by its own select only; output chip select plays no part
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            cfg_o <= CFG_CLEAR;
        end else if (reset_fall) begin
            cfg_o <= CFG_CLEAR;
        end else if (~csel_n_s & cclk_s & ~cclk_d_r) begin
            cfg_o <= {cfg_o[6:0], cdin_s};
        end
    end

    // ****************************************************************
    // conversion sequencer
    // ****************************************************************
    typedef enum logic [1:0] {ACP_IDLE, ACP_CONV} acp_state_t;
    acp_state_t state_r;                                 // sequencer state
    logic [5:0] cnt_r;                                   // cycles left
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            state_r <= ACP_IDLE;
            cnt_r   <= CNT_ZERO;
        end else if (reset_s) begin
            state_r <= ACP_IDLE;
            cnt_r   <= CNT_ZERO;
        end else begin
            case (state_r)
                ACP_IDLE: begin
                    // power-down inhibits only new starts
                    if (start_rise && !pd_s) begin
                        state_r <= ACP_CONV;
                        cnt_r   <= CONV_CYCLES;
                    end
                end
                ACP_CONV: begin
                    // running conversion completes even under power-down
                    if (cnt_r == CNT_ONE) begin
                        state_r <= ACP_IDLE;
                    end
                    cnt_r <= cnt_r - CNT_ONE;
                end
                default: begin
                    state_r <= ACP_IDLE;
                end
            endcase
        end
    end
    logic conv_done;                                     // last conversion cycle
    assign conv_done = (state_r == ACP_CONV) && (cnt_r == CNT_ONE) && !reset_s;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            busy_o <= 1'b0;
        end else begin
            busy_o <= (state_r == ACP_CONV) && !conv_done && !reset_s;
        end
    end

    // ****************************************************************
    // result register
    // ****************************************************************
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            data_o         <= DATA_ZERO;
            result_valid_o <= 1'b0;
        end else begin
            result_valid_o <= conv_done;                 // aborted runs never pulse
            if (reset_fall && coding_s) begin
                data_o <= DATA_ZERO;
            end else if (conv_done) begin
                data_o <= core_result_i;
            end
        end
    end

    // ****************************************************************
    // power-down status
    // ****************************************************************
    // limitation: reports power-down only once the sequencer is idle; core stays up until idle
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            powered_down_o <= 1'b0;
        end else begin
            powered_down_o <= pd_s && (state_r == ACP_IDLE);
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    property p_oe;
        @(posedge core_clk_i) disable iff (rst_i)
        (!cs_n_s && !rd_n_s) |=> data_oe_o;
    endproperty
    a_oe: assert property (p_oe) else $error("bus not enabled");

    property p_oe_off;
        @(posedge core_clk_i) disable iff (rst_i)
        (cs_n_s || rd_n_s) |=> !data_oe_o;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("bus enabled while deselected");

    property p_gate;
        @(posedge core_clk_i) disable iff (rst_i)
        cs_n_s |=> !sclk_edge_o;
    endproperty
    a_gate: assert property (p_gate) else $error("clock not gated");

    property p_abort;
        @(posedge core_clk_i) disable iff (rst_i)
        reset_s |=> !busy_o ##1 !result_valid_o;
    endproperty
    a_abort: assert property (p_abort) else $error("conversion not aborted");

    property p_zero;
        @(posedge core_clk_i) disable iff (rst_i)
        (reset_fall && coding_s) |=> (data_o == DATA_ZERO);
    endproperty
    a_zero: assert property (p_zero) else $error("data not zeroed");

    property p_cfg;
        @(posedge core_clk_i) disable iff (rst_i)
        reset_fall |=> (cfg_o == CFG_CLEAR);
    endproperty
    a_cfg: assert property (p_cfg) else $error("config not cleared");

    property p_pd;
        @(posedge core_clk_i) disable iff (rst_i)
        (pd_s && state_r == ACP_IDLE) |=> (state_r == ACP_IDLE);
    endproperty
    a_pd: assert property (p_pd) else $error("start under power-down");

    property p_range;
        @(posedge core_clk_i) disable iff (rst_i)
        !cfg_o[7] ##1 !cfg_o[7] |-> (range_o == $past({sgn_s, dbl_s}));
    endproperty
    a_range: assert property (p_range) else $error("range mismatch");

    property p_live;
        @(posedge core_clk_i) disable iff (rst_i)
        (pd_s && !cs_n_s && !rd_n_s) |=> data_oe_o;
    endproperty
    a_live: assert property (p_live) else $error("bus dead in power-down");
endmodule
`default_nettype wire

// ===== acp_host_model.sv
// host controller model that drives the converter control pins
`default_nettype none
module acp_host_model
    import acp_pkg::*;
(
    // clock
    input  wire logic                     core_clk_i,
    // control pins toward the device
    output logic                          dev_reset_o,
    output logic                          power_down_o,
    output logic                          coding_o,
    output var acp_pkg::acp_range_pins_t  range_o,
    output var acp_pkg::acp_read_pins_t   read_o,
    output logic                          slave_o,
    output logic                          sclk_o,
    output logic                          cfg_sel_n_o,
    output logic                          cfg_clk_o,
    output logic                          cfg_din_o,
    output logic                          start_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // idle pin levels, strobes inactive
    // ****************************************************************
    initial begin
        {dev_reset_o, power_down_o, coding_o, range_o, slave_o} = 6'h00;
        {sclk_o, cfg_clk_o, cfg_din_o, start_o} = 4'h0;
        read_o = 2'h3;
        cfg_sel_n_o = 1'b1;
    end

    // ****************************************************************
    // pin tasks; each waits out the 3-cycle pin path before returning
    // ****************************************************************
    task automatic gap(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask
    task automatic set_range(input logic s, input logic d);
        range_o <= '{signed_range: s, span_double_select: d};
        gap(6);
    endtask
    task automatic set_read(input logic cs_n, input logic rd_n);
        read_o <= '{cs_n: cs_n, rd_n: rd_n};
        gap(6);
    endtask
    task automatic set_misc(input logic pd, input logic cod, input logic sl);
        power_down_o <= pd;
        coding_o <= cod;
        slave_o <= sl;
        gap(6);
    endtask
    // a start level is held long enough for the synchroniser to see it
    task automatic do_start();
        start_o <= 1'b1;
        gap(4);
        start_o <= 1'b0;
        gap(2);
    endtask
    task automatic reset_pulse();
        dev_reset_o <= 1'b1;
        gap(6);
        dev_reset_o <= 1'b0;
        gap(6);
    endtask
    // serial clock runs only inside a burst, low otherwise
    task automatic sclk_burst(input int n);
        for (int k = 0; k < n; k++) begin
            sclk_o <= 1'b1;
            gap(3);
            sclk_o <= 1'b0;
            gap(3);
        end
    endtask
    // configuration byte, msb first, one bit per config clock rise
    task automatic cfg_write(input logic [7:0] b);
        cfg_sel_n_o <= 1'b0;
        for (int k = 7; k >= 0; k--) begin
            cfg_din_o <= b[k];
            gap(4);
            cfg_clk_o <= 1'b1;
            gap(4);
            cfg_clk_o <= 1'b0;
        end
        gap(4);
        cfg_sel_n_o <= 1'b1;
        cfg_din_o <= ~b[0];  // released line shows no stale bit
        gap(6);
    endtask
endmodule
`default_nettype wire

// ===== testbench.sv
// self-checking bench for the converter control-pin logic
`default_nettype none
module testbench
    import acp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk_i, rst_i, dr, pd, cod, sl, sck, csel, cclk, cdin, st;
    acp_range_pins_t rp;
    acp_read_pins_t  rdp;
    logic [15:0] res, data_o;
    logic [7:0]  cfg_o;
    logic [1:0]  range_o;
    logic        data_oe_o, busy_o, rv_o, edge_o, pdo;
    int errors = 0, checks_done = 0, sck_n = 0, rv_n = 0, rv0;

    initial begin
        core_clk_i = 1'b0;
        forever #2 core_clk_i = ~core_clk_i;
    end
    // count one-cycle pulses as they stand
    always @(posedge core_clk_i) begin
        sck_n += int'(edge_o === 1'b1);
        rv_n += int'(rv_o === 1'b1);
    end

    acp_host_model u_acp_host_model (.core_clk_i(core_clk_i), .dev_reset_o(dr),
        .power_down_o(pd), .coding_o(cod), .range_o(rp), .read_o(rdp), .slave_o(sl),
        .sclk_o(sck), .cfg_sel_n_o(csel), .cfg_clk_o(cclk), .cfg_din_o(cdin), .start_o(st));
    acp_ctrl u_acp_ctrl (.core_clk_i(core_clk_i), .rst_i(rst_i), .dev_reset_i(dr),
        .power_down_i(pd), .output_coding_select_i(cod), .range_pins_i(rp),
        .read_pins_i(rdp), .slave_mode_i(sl), .ext_sclk_i(sck), .cfg_sel_n_i(csel),
        .cfg_clk_i(cclk), .cfg_din_i(cdin), .conv_start_i(st), .core_result_i(res),
        .data_o(data_o), .data_oe_o(data_oe_o), .range_o(range_o), .busy_o(busy_o),
        .result_valid_o(rv_o), .sclk_edge_o(edge_o), .powered_down_o(pdo), .cfg_o(cfg_o));

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic give_verdict();
        if (errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        rst_i = 1'b1;
        res = 16'ha5c3;
        repeat (16) @(posedge core_clk_i);
        rst_i <= 1'b0;
        u_acp_host_model.gap(2);
        chk("data_oe_o", 16'h0000, {15'h0, data_oe_o});
        u_acp_host_model.gap(2);
        for (int i = 0; i < 4; i++) begin
            u_acp_host_model.set_range(i[1], i[0]);
            chk("range_o", 16'(i), {14'h0, range_o});
        end
        for (int j = 0; j < 4; j++) begin
            u_acp_host_model.set_read(j[1], j[0]);
            chk("data_oe_o", 16'(j == 0), {15'h0, data_oe_o});
        end
        // clock edges with the output deselected are ignored
        u_acp_host_model.set_misc(1'b0, 1'b0, 1'b1);
        u_acp_host_model.sclk_burst(5);
        chk("sclk edges", 16'h0000, 16'(sck_n));
        u_acp_host_model.set_read(1'b0, 1'b1);
        u_acp_host_model.sclk_burst(5);
        chk("sclk edges", 16'h0005, 16'(sck_n));
        // with slave mode off the selected serial clock is not taken either
        u_acp_host_model.set_misc(1'b0, 1'b0, 1'b0);
        u_acp_host_model.sclk_burst(5);
        chk("sclk edges", 16'h0005, 16'(sck_n));
        // config port works with the output chip select high
        u_acp_host_model.set_read(1'b1, 1'b1);
        u_acp_host_model.cfg_write(8'h81);
        chk("cfg_o", 16'h0081, {8'h0, cfg_o});
        chk("range_o", 16'h0001, {14'h0, range_o});
        rv0 = rv_n;
        u_acp_host_model.do_start();
        u_acp_host_model.gap(40);
        chk("results", 16'(rv0 + 1), 16'(rv_n));
        chk("data_o", 16'ha5c3, data_o);
        // abort in mid-conversion, coding low keeps the data
        u_acp_host_model.do_start();
        chk("busy_o", 16'h0001, {15'h0, busy_o});
        u_acp_host_model.reset_pulse();
        u_acp_host_model.gap(40);
        chk("results", 16'(rv0 + 1), 16'(rv_n));
        chk("data_o", 16'ha5c3, data_o);
        chk("cfg_o", 16'h0000, {8'h0, cfg_o});
        chk("range_o", 16'h0003, {14'h0, range_o});
        chk("busy_o", 16'h0000, {15'h0, busy_o});
        u_acp_host_model.set_misc(1'b0, 1'b1, 1'b1);
        u_acp_host_model.reset_pulse();
        chk("data_o", 16'h0000, data_o);
        // power-down lands during a conversion
        res <= 16'h1234;
        u_acp_host_model.do_start();
        u_acp_host_model.set_misc(1'b1, 1'b1, 1'b1);
        chk("busy_o", 16'h0001, {15'h0, busy_o});
        chk("powered_down_o", 16'h0000, {15'h0, pdo});
        u_acp_host_model.gap(40);
        chk("results", 16'(rv0 + 2), 16'(rv_n));
        chk("data_o", 16'h1234, data_o);
        chk("powered_down_o", 16'h0001, {15'h0, pdo});
        u_acp_host_model.do_start();
        u_acp_host_model.gap(40);
        chk("results", 16'(rv0 + 2), 16'(rv_n));
        u_acp_host_model.set_read(1'b0, 1'b0);
        chk("data_oe_o", 16'h0001, {15'h0, data_oe_o});
        u_acp_host_model.set_read(1'b1, 1'b0);
        chk("data_oe_o", 16'h0000, {15'h0, data_oe_o});
        u_acp_host_model.set_misc(1'b0, 1'b1, 1'b1);
        u_acp_host_model.do_start();
        u_acp_host_model.gap(40);
        chk("results", 16'(rv0 + 3), 16'(rv_n));
        chk("powered_down_o", 16'h0000, {15'h0, pdo});
        give_verdict();
    end

    // watchdog: the sequence needs well under 2000 cycles
    initial begin
        repeat (5000) @(posedge core_clk_i);
        errors++;
        give_verdict();
    end
endmodule
`default_nettype wire
